// ==== pkg/adcseq_pkg.sv ====
package adcseq_pkg;

    // Register byte addresses on the internal bus.
    localparam logic [15:0] ADDR_RESULT_A_HIGH = 16'hFFE0;
    localparam logic [15:0] ADDR_RESULT_A_LOW = 16'hFFE1;
    localparam logic [15:0] ADDR_RESULT_B_HIGH = 16'hFFE2;
    localparam logic [15:0] ADDR_RESULT_B_LOW = 16'hFFE3;
    localparam logic [15:0] ADDR_RESULT_C_HIGH = 16'hFFE4;
    localparam logic [15:0] ADDR_RESULT_C_LOW = 16'hFFE5;
    localparam logic [15:0] ADDR_RESULT_D_HIGH = 16'hFFE6;
    localparam logic [15:0] ADDR_RESULT_D_LOW = 16'hFFE7;
    localparam logic [15:0] ADDR_CONTROL_STATUS = 16'hFFE8;

    // Control/status field positions.
    localparam int BIT_END_FLAG = 7;
    localparam int BIT_INT_ENABLE = 6;
    localparam int BIT_START = 5;
    localparam int BIT_SCAN = 4;
    localparam int BIT_TIME_SELECT = 3;
    localparam int BIT_GROUP = 2;
    localparam int BIT_INDEX_HIGH = 1;
    localparam int BIT_INDEX_LOW = 0;

    // Reset values.
    localparam logic [7:0] RESET_CONTROL_STATUS = 8'h00;
    localparam logic [9:0] RESET_RESULT = 10'h000;
    localparam logic [7:0] RESET_LATCH = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // Result word layout and unused low-byte bits.
    localparam int RESULT_BITS = 10;
    localparam logic [5:0] LOW_UNUSED = 6'h00;

    // Conversion times in states; one state is one core clock.
    localparam int CYCLES_PER_STATE = 1;
    localparam int FIRST_SLOW_STATES = 274;
    localparam int FIRST_FAST_STATES = 138;
    localparam int NEXT_SLOW_STATES = 256;
    localparam int NEXT_FAST_STATES = 128;
    localparam logic [8:0] FIRST_SLOW_CYCLES = 9'(FIRST_SLOW_STATES * CYCLES_PER_STATE);
    localparam logic [8:0] FIRST_FAST_CYCLES = 9'(FIRST_FAST_STATES * CYCLES_PER_STATE);
    localparam logic [8:0] NEXT_SLOW_CYCLES = 9'(NEXT_SLOW_STATES * CYCLES_PER_STATE);
    localparam logic [8:0] NEXT_FAST_CYCLES = 9'(NEXT_FAST_STATES * CYCLES_PER_STATE);

    typedef enum logic [0:0] {
        S_IDLE,
        S_CONV
    } adcseq_state_t;

endpackage

// ==== pkg/adcseq_store_if.sv ====
`timescale 1ns/1ps
interface adcseq_store_if;
    logic store;
    logic [1:0] idx;
    logic [9:0] data;
    logic clear;

    modport source (
        output store,
        output idx,
        output data,
        output clear
    );
    modport sink (
        input store,
        input idx,
        input data,
        input clear
    );
endinterface

// ==== core/adcseq_timer.sv ====
`timescale 1ns/1ps
module adcseq_timer
    import adcseq_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Control
    input wire logic load,
    input wire logic abort,
    input wire logic [8:0] length,
    // Status
    output logic done
);

    logic [8:0] count;
    logic running;

    // Done fires exactly length cycles after the load edge.
    assign done = running && (count == 9'h001);

    always_ff @(posedge core_clk) begin
        if (rst || abort) begin
            running <= 1'b0;
            count <= 9'h000;
        end else if (load) begin
            running <= 1'b1;
            count <= length;
        end else if (done) begin
            running <= 1'b0;
            count <= 9'h000;
        end else if (running) begin
            count <= count - 9'h001;
        end
    end

endmodule

// ==== core/adcseq_results.sv ====
`timescale 1ns/1ps
module adcseq_results
    import adcseq_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Store side
    adcseq_store_if.sink st,
    // Read side
    input wire logic [1:0] rd_idx,
    input wire logic rd_high,
    output logic [7:0] high_byte,
    output logic [7:0] low_latch
);

    logic [RESULT_BITS-1:0] result [4];

    wire [7:0] live_low = {result[rd_idx][1:0], LOW_UNUSED};

    // Top eight bits form the high byte.
    assign high_byte = result[rd_idx][9:2];

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_reg
            always_ff @(posedge core_clk) begin
                if (rst || st.clear) begin
                    result[g] <= RESET_RESULT;
                end else if (st.store && st.idx == 2'(g)) begin
                    result[g] <= st.data;
                end
            end
        end
    endgenerate

    // The low byte is caught when the high byte goes out, so a high-then-low pair matches.
    always_ff @(posedge core_clk) begin
        if (rst || st.clear) begin
            low_latch <= RESET_LATCH;
        end else if (rd_high) begin
            low_latch <= live_low;
        end
    end

endmodule

// ==== core/adcseq_top.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// RULE_01: Result high byte holds top eight bits.
// RULE_02: Six unused low bits read zero.
// RULE_03: Reset or standby clears all results.
// RULE_04: Register index is input number modulo four.
// RULE_05: Result registers ignore bus writes.
// RULE_06: Reset or standby clears control/status.
// RULE_07: End flag cleared by read-one-write-zero only.
// RULE_08: Transfer controller service clears end flag.
// RULE_09: Flag sets per single conversion or scan cycle.
// RULE_10: Interrupt requested only with enable set.
// RULE_11: Converter runs only while start set.
// RULE_12: Single mode converts once, clears start.
// RULE_13: Scan repeats until start cleared.
// RULE_14: Mode bit selects single or scan.
// RULE_15: First conversion takes 274 or 138 states.
// RULE_16: Single mode converts group and index input.
// RULE_17: Scan covers group inputs zero to index.
// RULE_18: Software changes settings only while stopped.
// RULE_19: High byte read loads low-byte latch.
// RULE_20: Low byte read returns latch contents.
// RULE_21: Full result needs high byte first.
// RULE_22: Eight-bit readers may read high only.
// RULE_23: Single end stores, flags, clears start, halts.
// RULE_24: Next scan channel starts immediately.
// RULE_25: Later scan conversions take 256 or 128 states.
// RULE_26: Interrupt level is flag and enable.
module adcseq_top
    import adcseq_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Chip power state
    input wire logic standby,
    // Internal bus
    input wire logic [15:0] bus_addr,
    input wire logic bus_rd,
    input wire logic bus_wr,
    input wire logic [7:0] bus_wdata,
    output logic [7:0] bus_rdata,
    // Transfer controller
    input wire logic xfer_service,
    // Interrupt
    output logic conversion_end_interrupt,
    // Analog side
    input wire logic [9:0] conv_result,
    output logic conv_busy,
    output logic [2:0] conv_channel
);

    function automatic logic is_result(input logic [15:0] addr);
        is_result = (addr >= ADDR_RESULT_A_HIGH) && (addr <= ADDR_RESULT_D_LOW);
    endfunction

    function automatic logic [1:0] result_index(input logic [15:0] addr);
        result_index = addr[2:1];
    endfunction

    // Control/status fields.
    logic conversion_end_flag;
    logic end_interrupt_enable;
    logic start_bit;
    logic scan_mode;
    logic conversion_time_select;
    logic group_select_bit;
    logic channel_index_high;
    logic channel_index_low;

    logic flag_armed;
    logic [1:0] scan_idx;
    adcseq_state_t state;
    adcseq_state_t next_state;

    logic next_flag;
    logic next_enable;
    logic next_start;
    logic [1:0] next_scan_idx;

    adcseq_store_if st ();

    wire done;
    wire [7:0] high_byte;
    wire [7:0] low_latch;

    // Bus decode.
    wire csr_hit = (bus_addr == ADDR_CONTROL_STATUS);
    wire res_hit = is_result(bus_addr);
    wire wr_ctrl = bus_wr && csr_hit;
    wire rd_ctrl = bus_rd && csr_hit;
    wire rd_res_high = bus_rd && res_hit && !bus_addr[0]; // RULE_19
    wire [1:0] rd_idx = result_index(bus_addr);

    wire [1:0] chan_index = {channel_index_high, channel_index_low};
    wire [7:0] csr_value = {
        conversion_end_flag,
        end_interrupt_enable,
        start_bit,
        scan_mode,
        conversion_time_select,
        group_select_bit,
        channel_index_high,
        channel_index_low
    };

    // Channel in work: fixed index in single mode, running index in scan.
    wire [1:0] cur_idx = scan_mode ? scan_idx : chan_index; // RULE_14 RULE_16 RULE_17
    wire last_in_scan = (scan_idx == chan_index); // RULE_17

    wire converting = (state == S_CONV);
    wire conv_done = converting && done;
    wire single_end = conv_done && !scan_mode; // RULE_23
    wire cycle_end = conv_done && (!scan_mode || last_in_scan); // RULE_09

    // Timer loads.
    wire load_first = (state == S_IDLE) && start_bit && !standby; // RULE_11
    wire load_next = conv_done && scan_mode && start_bit && !standby; // RULE_24
    wire halt = converting && !start_bit; // RULE_11
    wire timer_load = load_first || load_next;

    wire [8:0] first_len = conversion_time_select ? FIRST_FAST_CYCLES
                                                  : FIRST_SLOW_CYCLES; // RULE_15
    wire [8:0] next_len = conversion_time_select ? NEXT_FAST_CYCLES
                                                 : NEXT_SLOW_CYCLES; // RULE_25
    wire [8:0] timer_len = load_first ? first_len : next_len;

    // Flag clear conditions.
    wire sw_clear = wr_ctrl && !bus_wdata[BIT_END_FLAG] && flag_armed; // RULE_07
    wire flag_clear = sw_clear || xfer_service; // RULE_08

    // Results go to the register that owns the input's slot in its group.
    assign st.store = conv_done;
    assign st.idx = cur_idx; // RULE_04
    assign st.data = conv_result; // RULE_01
    assign st.clear = standby; // RULE_03

    // Standby also stops the timer, so a conversion cut short never stores a result.
    adcseq_timer u_timer (
        .core_clk(core_clk),
        .rst(rst || standby),
        .load(timer_load),
        .abort(halt),
        .length(timer_len),
        .done(done)
    );

    adcseq_results u_results (
        .core_clk(core_clk),
        .rst(rst),
        .st(st),
        .rd_idx(rd_idx),
        .rd_high(rd_res_high),
        .high_byte(high_byte),
        .low_latch(low_latch)
    );

    // A completion in the same cycle as a clear keeps the flag set.
    always_comb begin
        next_flag = conversion_end_flag;
        if (standby) begin
            next_flag = 1'b0;
        end else if (cycle_end) begin
            next_flag = 1'b1; // RULE_09
        end else if (flag_clear) begin
            next_flag = 1'b0; // RULE_07 RULE_08
        end
    end

    always_comb begin
        next_enable = end_interrupt_enable;
        if (standby) begin
            next_enable = 1'b0;
        end else if (wr_ctrl) begin
            next_enable = bus_wdata[BIT_INT_ENABLE];
        end
    end

    // Hardware clears start at a single-mode end; a write in that very cycle
    // still lands, so software can restart back to back.
    always_comb begin
        next_start = start_bit;
        if (standby) begin
            next_start = 1'b0;
        end else if (wr_ctrl) begin
            next_start = bus_wdata[BIT_START]; // RULE_11
        end else if (single_end) begin
            next_start = 1'b0; // RULE_12 RULE_23
        end
    end

    // A fresh scan start always begins at the group's first input.
    always_comb begin
        next_scan_idx = scan_idx;
        if (standby || load_first) begin
            next_scan_idx = 2'b00; // RULE_17
        end else if (conv_done && scan_mode) begin
            next_scan_idx = last_in_scan ? 2'b00 : scan_idx + 2'b01; // RULE_13
        end
    end

    always_comb begin
        next_state = state;
        unique case (state)
            S_IDLE: begin
                if (load_first) begin
                    next_state = S_CONV;
                end
            end
            S_CONV: begin
                if (standby || halt) begin
                    next_state = S_IDLE; // RULE_11
                end else if (single_end) begin
                    next_state = S_IDLE; // RULE_23
                end else if (conv_done && !start_bit) begin
                    next_state = S_IDLE;
                end
            end
        endcase
    end

    // Status bits; standby is already folded into their next values.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            conversion_end_flag <= RESET_CONTROL_STATUS[BIT_END_FLAG]; // RULE_06
            end_interrupt_enable <= RESET_CONTROL_STATUS[BIT_INT_ENABLE];
            start_bit <= RESET_CONTROL_STATUS[BIT_START];
        end else begin
            conversion_end_flag <= next_flag;
            end_interrupt_enable <= next_enable;
            start_bit <= next_start;
        end
    end

    // Settings written mid-run take effect at once; stopping first is up to software.
    always_ff @(posedge core_clk) begin
        if (rst || standby) begin
            scan_mode <= RESET_CONTROL_STATUS[BIT_SCAN]; // RULE_06
            conversion_time_select <= RESET_CONTROL_STATUS[BIT_TIME_SELECT];
            group_select_bit <= RESET_CONTROL_STATUS[BIT_GROUP];
            channel_index_high <= RESET_CONTROL_STATUS[BIT_INDEX_HIGH];
            channel_index_low <= RESET_CONTROL_STATUS[BIT_INDEX_LOW];
        end else if (wr_ctrl) begin
            scan_mode <= bus_wdata[BIT_SCAN]; // RULE_14
            conversion_time_select <= bus_wdata[BIT_TIME_SELECT];
            group_select_bit <= bus_wdata[BIT_GROUP];
            channel_index_high <= bus_wdata[BIT_INDEX_HIGH];
            channel_index_low <= bus_wdata[BIT_INDEX_LOW];
        end
    end

    // Software can clear the flag only after it has read it as one.
    always_ff @(posedge core_clk) begin
        if (rst || standby) begin
            flag_armed <= 1'b0;
        end else if (wr_ctrl) begin
            flag_armed <= 1'b0; // RULE_07
        end else if (rd_ctrl && conversion_end_flag) begin
            flag_armed <= 1'b1; // RULE_07
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state <= S_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            scan_idx <= 2'b00;
        end else begin
            scan_idx <= next_scan_idx;
        end
    end

    // Read data; result writes fall through the decode and change nothing.
    wire [7:0] res_value = bus_addr[0] ? low_latch : high_byte; // RULE_05 RULE_20
    wire [7:0] rd_value = csr_hit ? csr_value
                        : res_hit ? res_value
                        : READ_UNMAPPED;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            bus_rdata <= READ_UNMAPPED;
        end else if (bus_rd) begin
            bus_rdata <= rd_value; // RULE_02 RULE_20
        end
    end

    // Interrupt follows the next flag so it drops with the flag, not after.
    wire next_request = next_flag && next_enable; // RULE_26

    always_ff @(posedge core_clk) begin
        if (rst) begin
            conversion_end_interrupt <= 1'b0;
        end else begin
            conversion_end_interrupt <= next_request; // RULE_10 RULE_26
        end
    end

    // Analog side sees the channel one cycle after the decision.
    wire [2:0] next_channel = {group_select_bit, scan_mode ? next_scan_idx : chan_index};

    always_ff @(posedge core_clk) begin
        if (rst) begin
            conv_busy <= 1'b0;
        end else begin
            conv_busy <= (next_state == S_CONV);
        end
    end

    // The result is taken at the timer's end, so the channel must stand until then.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            conv_channel <= 3'h0;
        end else begin
            conv_channel <= next_channel; // RULE_16 RULE_17
        end
    end

endmodule

// ==== verification/adcseq_analog_model.sv ====
`timescale 1ns/1ps
module adcseq_analog_model
(
    // Channel being converted
    input wire logic [2:0] conv_channel,
    // Result handed back
    output logic [9:0] conv_result
);
    // Each input gives its own pattern so a result stored in the wrong register shows up.
    assign conv_result = {conv_channel, conv_channel, conv_channel, ~conv_channel[0]};
endmodule

// ==== verification/adcseq_checker.sv ====
`timescale 1ns/1ps
module adcseq_checker
    import adcseq_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Chip power state
    input wire logic standby,
    // Internal bus
    input wire logic [15:0] bus_addr,
    input wire logic bus_rd,
    input wire logic bus_wr,
    input wire logic [7:0] bus_wdata,
    input wire logic [7:0] bus_rdata,
    // Transfer controller
    input wire logic xfer_service,
    // Interrupt
    input wire logic conversion_end_interrupt,
    // Analog side
    input wire logic [9:0] conv_result,
    input wire logic conv_busy,
    input wire logic [2:0] conv_channel
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    logic csr_wr;
    logic low_rd;
    logic bad_rd;
    logic go_wr;
    logic [2:0] next_start_ch;
    logic [2:0] start_ch;
    assign csr_wr = bus_wr && bus_addr == ADDR_CONTROL_STATUS;
    assign low_rd = bus_rd && bus_addr[15:3] == 13'h1ffc && bus_addr[0];
    assign bad_rd = bus_rd && (bus_addr < ADDR_RESULT_A_HIGH || bus_addr > ADDR_CONTROL_STATUS);
    assign go_wr = csr_wr && bus_wdata[BIT_START] && !conv_busy && !standby;
    // Scan always begins at the first input of the group.
    assign next_start_ch = bus_wdata[BIT_SCAN] ? {bus_wdata[BIT_GROUP], 2'h0} : bus_wdata[2:0];

    always_ff @(posedge core_clk) begin
        if (csr_wr) begin
            start_ch <= next_start_ch;
        end
    end

    unmapped_read_a: assert property (bad_rd |=> bus_rdata == READ_UNMAPPED)
        else $error("unmapped read not zero");
    low_bits_zero_a: assert property (low_rd |=> bus_rdata[5:0] == LOW_UNUSED)
        else $error("unused low bits not zero");
    enable_off_a: assert property (csr_wr && !bus_wdata[BIT_INT_ENABLE] |=>
        !conversion_end_interrupt) else $error("interrupt with enable clear");
    service_clear_a: assert property (xfer_service && !conv_busy |=>
        !conversion_end_interrupt) else $error("service left interrupt set");
    standby_irq_a: assert property (standby |=> !conversion_end_interrupt)
        else $error("interrupt survives standby");
    standby_stop_a: assert property (standby |=> !conv_busy)
        else $error("conversion survives standby");
    irq_cause_a: assert property ($rose(conversion_end_interrupt) |->
        $past(conv_busy) || $past(csr_wr)) else $error("interrupt without cause");
    busy_cause_a: assert property ($rose(conv_busy) |->
        $past(csr_wr, 2) || $past(csr_wr, 3)) else $error("conversion without start");
    start_run_a: assert property (go_wr |=> ##[0:2]
        (conv_busy && conv_channel == start_ch)) else $error("start not taken");

    cover property ($rose(conversion_end_interrupt));
    cover property (xfer_service && conversion_end_interrupt);
    cover property (standby && conv_busy);
endmodule

bind adcseq_top adcseq_checker u_adcseq_checker (
    .core_clk(core_clk),
    .rst(rst),
    .standby(standby),
    .bus_addr(bus_addr),
    .bus_rd(bus_rd),
    .bus_wr(bus_wr),
    .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata),
    .xfer_service(xfer_service),
    .conversion_end_interrupt(conversion_end_interrupt),
    .conv_result(conv_result),
    .conv_busy(conv_busy),
    .conv_channel(conv_channel)
);

// ==== verification/test_adc_sequencer_regs.sv ====
`timescale 1ns/1ps
module test_adc_sequencer_regs;
    import adcseq_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic standby = 1'b0;
    logic [15:0] bus_addr = 16'h0000;
    logic bus_rd = 1'b0;
    logic bus_wr = 1'b0;
    logic [7:0] bus_wdata = 8'h00;
    logic xfer_service = 1'b0;
    logic [7:0] bus_rdata;
    logic conversion_end_interrupt;
    logic [9:0] conv_result;
    logic conv_busy;
    logic [2:0] conv_channel;
    int error_cnt = 0;
    int checked = 0;
    int n;
    logic [7:0] rv;

    always #25 core_clk = ~core_clk;

    adcseq_top u_adcseq_top (
        .core_clk(core_clk),
        .rst(rst),
        .standby(standby),
        .bus_addr(bus_addr),
        .bus_rd(bus_rd),
        .bus_wr(bus_wr),
        .bus_wdata(bus_wdata),
        .bus_rdata(bus_rdata),
        .xfer_service(xfer_service),
        .conversion_end_interrupt(conversion_end_interrupt),
        .conv_result(conv_result),
        .conv_busy(conv_busy),
        .conv_channel(conv_channel)
    );

    adcseq_analog_model u_adcseq_analog_model (
        .conv_channel(conv_channel),
        .conv_result(conv_result)
    );

    function automatic logic [9:0] res_of(input logic [2:0] ch);
        return {ch, ch, ch, ~ch[0]};
    endfunction

    task automatic finish_test();
        if (error_cnt == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmpn(input string what, input int exp, input int got);
        checked++;
        if (got != exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk);
        #1;
        bus_addr = a;
        bus_wdata = d;
        bus_wr = 1'b1;
        @(posedge core_clk);
        #1;
        bus_wr = 1'b0;
    endtask

    task automatic rchk(input string what, input logic [15:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        #1;
        bus_addr = a;
        bus_rd = 1'b1;
        @(posedge core_clk);
        #1;
        bus_rd = 1'b0;
        rv = bus_rdata;
        cmp8(what, exp, rv);
    endtask

    // Reads a whole result high byte first so the pair is consistent.
    task automatic rres(input string what, input logic [15:0] a, input logic [2:0] ch);
        logic [9:0] r;
        r = res_of(ch);
        rchk(what, a, r[9:2]);
        rchk(what, a + 16'h0001, {r[1:0], 6'h00});
    endtask

    task automatic wait_irq(input int lim);
        n = 0;
        while (conversion_end_interrupt !== 1'b1) begin
            @(posedge core_clk);
            #1;
            n++;
            if (n > lim) begin
                error_cnt++;
                $display("CHECK FAILED irq wait expected %0d seen %0d", lim, n);
                finish_test();
            end
        end
    endtask

    task automatic service();
        @(posedge core_clk);
        #1;
        xfer_service = 1'b1;
        @(posedge core_clk);
        #1;
        xfer_service = 1'b0;
    endtask

    task automatic t_reset();
        for (int i = 0; i < 9; i++) begin
            rchk("reset value", ADDR_RESULT_A_HIGH + 16'(i), 8'h00);
        end
    endtask

    task automatic t_single();
        wr(ADDR_CONTROL_STATUS, 8'h61);
        wait_irq(400);
        cmpn("slow time", 275, n);
        rchk("status", ADDR_CONTROL_STATUS, 8'hc1);
        rres("result b", ADDR_RESULT_B_HIGH, 3'd1);
        wr(ADDR_CONTROL_STATUS, 8'h41);
        cmp8("irq", 8'h00, {7'h00, conversion_end_interrupt});
        wr(ADDR_CONTROL_STATUS, 8'hc0);
        rchk("status", ADDR_CONTROL_STATUS, 8'h40);
    endtask

    task automatic t_fast();
        wr(ADDR_CONTROL_STATUS, 8'h6c);
        wait_irq(300);
        cmpn("fast time", 139, n);
        // The last write disarmed the clear, so this write must leave the flag.
        wr(ADDR_CONTROL_STATUS, 8'h40);
        rchk("status", ADDR_CONTROL_STATUS, 8'hc0);
        service();
        cmp8("irq", 8'h00, {7'h00, conversion_end_interrupt});
        rchk("status", ADDR_CONTROL_STATUS, 8'h40);
        rres("result a", ADDR_RESULT_A_HIGH, 3'd4);
    endtask

    task automatic t_ie_off();
        wr(ADDR_CONTROL_STATUS, 8'h23);
        repeat (280) @(posedge core_clk);
        #1;
        cmp8("irq", 8'h00, {7'h00, conversion_end_interrupt});
        rchk("status", ADDR_CONTROL_STATUS, 8'h83);
        rres("result d", ADDR_RESULT_D_HIGH, 3'd3);
        wr(ADDR_CONTROL_STATUS, 8'h00);
    endtask

    task automatic t_scan();
        wr(ADDR_CONTROL_STATUS, 8'h72);
        wait_irq(1000);
        cmpn("scan first", 787, n);
        service();
        wait_irq(1000);
        cmpn("scan repeat", 766, n);
        rchk("status", ADDR_CONTROL_STATUS, 8'hf2);
        for (int i = 0; i < 3; i++) begin
            rres("scan result", ADDR_RESULT_A_HIGH + 16'(2 * i), 3'(i));
        end
        rres("result d", ADDR_RESULT_D_HIGH, 3'd3);
        wr(ADDR_CONTROL_STATUS, 8'h52);
        repeat (300) @(posedge core_clk);
        #1;
        cmp8("busy", 8'h00, {7'h00, conv_busy});
        rchk("status", ADDR_CONTROL_STATUS, 8'h52);
    endtask

    task automatic t_misc();
        logic [9:0] r;
        r = res_of(3'd0);
        wr(ADDR_RESULT_A_HIGH, 8'hff);
        wr(ADDR_RESULT_A_LOW, 8'hff);
        rchk("read only", ADDR_RESULT_A_HIGH, r[9:2]);
        rchk("unmapped", 16'hffe9, 8'h00);
        wr(ADDR_CONTROL_STATUS, 8'h71);
        repeat (5) @(posedge core_clk);
        #1;
        standby = 1'b1;
        repeat (2) @(posedge core_clk);
        #1;
        standby = 1'b0;
        cmp8("busy", 8'h00, {7'h00, conv_busy});
        rchk("standby status", ADDR_CONTROL_STATUS, 8'h00);
        rchk("standby result", ADDR_RESULT_B_HIGH, 8'h00);
        rchk("standby result", ADDR_RESULT_B_LOW, 8'h00);
    endtask

    task automatic t_scan_fast();
        wr(ADDR_CONTROL_STATUS, 8'h7d);
        wait_irq(400);
        cmpn("fast scan", 267, n);
        wr(ADDR_CONTROL_STATUS, 8'h5d);
        rchk("status", ADDR_CONTROL_STATUS, 8'hdd);
        rres("scan result", ADDR_RESULT_A_HIGH, 3'd4);
        rres("scan result", ADDR_RESULT_B_HIGH, 3'd5);
        rchk("scan end", ADDR_RESULT_C_HIGH, 8'h00);
    endtask

    initial begin
        repeat (3) @(posedge core_clk);
        #1;
        rst = 1'b0;
        t_reset();
        t_single();
        t_fast();
        t_ie_off();
        t_scan();
        t_misc();
        t_scan_fast();
        finish_test();
    end
endmodule
